// File: pkg/facc_pkg.sv
// Constants, types and register map of the fan auto-control block.
// Assumes a 200 MHz core clock and word-indexed Wishbone registers.
package facc_pkg;
    // ****************************************************************
    // Register indices (byte address = 4 * index)
    // ****************************************************************
    localparam logic [7:0] IDX_STATUS = 8'h03;
    localparam logic [7:0] IDX_SPINUP = 8'h20;
    localparam logic [7:0] IDX_SPEED  = 8'h22;
    localparam logic [7:0] IDX_FILTER = 8'h23;
    localparam logic [7:0] IDX_LOCAL  = 8'h24;
    localparam logic [7:0] IDX_REMOTE = 8'h25;
    localparam logic [7:0] IDX_OTREV  = 8'h3F;

    // ****************************************************************
    // Reset values and field positions
    // ****************************************************************
    localparam logic [7:0] RST_SPEED  = 8'h05;
    localparam logic [7:0] RST_FILTER = 8'h50;
    localparam logic [7:0] RST_LOCAL  = 8'h41;
    localparam logic [7:0] RST_REMOTE = 8'h61;
    localparam logic [7:0] RST_SPINUP = 8'h05;
    localparam logic       RST_OT_EN  = 1'b1;
    localparam int F_SPIN_DIS = 7;
    localparam int F_RAMP_LSB = 5;
    localparam int F_RATE_LSB = 2;
    localparam int F_FILT_EN  = 0;
    localparam int F_TMIN_LSB = 3;
    localparam int F_OT_EN    = 7;
    localparam int F_AUTO_EN  = 7;
    localparam int F_EXT_FLAG = 7;

    // ****************************************************************
    // Timing and scaling
    // ****************************************************************
    localparam longint CLK_HZ        = 200_000_000;
    localparam longint SPIN_UNIT_MS  = 200;
    localparam longint SPIN_UNIT_CYC = SPIN_UNIT_MS * CLK_HZ / 1000;
    localparam longint UPD_DEF_S     = 1;
    localparam longint UPD_DEF_CYC   = UPD_DEF_S * CLK_HZ;
    localparam longint PWM_FREQ_MHZ  = 31_250;
    localparam longint PWM_SLOTS     = 16;
    localparam longint PWM_SLOT_CYC  = CLK_HZ * 1000 / (PWM_FREQ_MHZ * PWM_SLOTS);
    localparam logic [3:0] DUTY_MAX  = 4'hF;
    localparam logic [2:0] SPAN_MAX  = 3'h4;
    localparam logic [3:0] SPAN_K    = 4'hD;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        FS_IDLE = 2'b00,
        FS_SPIN = 2'b01,
        FS_RUN  = 2'b10
    } facc_fan_state_t;

    typedef struct packed {
        logic [3:0] base;
        logic       spin_dis;
        logic [1:0] ramp;
        logic [2:0] rate;
        logic       filt_en;
        logic [4:0] l_tmin;
        logic [2:0] l_span;
        logic [4:0] r_tmin;
        logic [2:0] r_span;
        logic       ot_en;
        logic       auto_en;
        logic [2:0] spin_code;
    } facc_cfg_t;
endpackage

// File: rtl/facc_top.sv
// Fan auto-control: config registers, spin-up, ramp, overtemp and PWM.
// Assumes a classic Wishbone master and synchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none

module facc_top
    import facc_pkg::*;
#(
    parameter logic [31:0] SPIN_CYC = 32'(SPIN_UNIT_CYC),
    parameter logic [31:0] UPD_CYC  = 32'(UPD_DEF_CYC),
    parameter logic [31:0] SLOT_CYC = 32'(PWM_SLOT_CYC),
    parameter logic [3:0]  REVISION = 4'h1
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [7:0]  local_temp,
    input  wire logic [7:0]  remote_temp,
    input  wire logic        overtemp_req,
    input  wire logic        therm_i,
    output logic             therm_o,
    output logic             therm_oe_n,
    output logic             pwm_out
);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [3:0] auto_level(input logic [7:0] temp,
                                              input logic [4:0] tmin,
                                              input logic [2:0] span,
                                              input logic [3:0] base);
        logic [7:0]  t0;
        logic [2:0]  sc;
        logic [7:0]  d;
        logic [11:0] inc;
        logic [11:0] sum;
        t0  = {1'b0, tmin, 2'b00};
        sc  = (span > SPAN_MAX) ? SPAN_MAX : span;
        d   = temp - t0;
        inc = (12'(d) * 12'(SPAN_K)) >> (sc + 3'h2);
        sum = 12'(base) + inc;
        if (temp <= t0) begin
            auto_level = base;
        end else if (d >= 8'(8'h05 << sc)) begin
            auto_level = DUTY_MAX;
        end else begin
            auto_level = (sum > 12'(DUTY_MAX)) ? DUTY_MAX : sum[3:0];
        end
    endfunction

    function automatic logic [31:0] spin_limit(input logic [2:0] code);
        logic [5:0] mult;
        case (code)
            3'h0: mult = 6'h01;
            3'h1: mult = 6'h02;
            3'h2: mult = 6'h03;
            3'h3: mult = 6'h04;
            3'h4: mult = 6'h05;
            3'h5: mult = 6'h0A;
            3'h6: mult = 6'h14;
            default: mult = 6'h28;
        endcase
        spin_limit = 32'(longint'(mult) * longint'(SPIN_CYC));
    endfunction

    // ****************************************************************
    // Register file and Wishbone slave
    // ****************************************************************
    logic [3:0]  speed_q;
    logic [7:0]  filter_q;
    logic [7:0]  local_q;
    logic [7:0]  remote_q;
    logic [7:0]  spinup_q;
    logic        ot_en_q;
    logic        ext_flag_q;
    logic [31:0] rdata_q;
    logic        ack_q;
    facc_cfg_t   cfg;

    wire logic [7:0] idx     = wb_adr_i[9:2];
    wire logic       req     = wb_cyc_i & wb_stb_i & ~ack_q;
    wire logic       done    = wb_cyc_i & wb_stb_i & ack_q;
    wire logic       wr      = done & wb_we_i & wb_sel_i[0];
    wire logic [7:0] wd      = wb_dat_i[7:0];
    wire logic       st_read = done & ~wb_we_i & (idx == IDX_STATUS);
    logic [7:0]      rd_byte;

    always_comb begin
        case (idx)
            IDX_STATUS: rd_byte = {ext_flag_q, 7'h00};
            IDX_SPINUP: rd_byte = spinup_q;
            IDX_SPEED:  rd_byte = {4'h0, speed_q};
            IDX_FILTER: rd_byte = filter_q;
            IDX_LOCAL:  rd_byte = local_q;
            IDX_REMOTE: rd_byte = remote_q;
            IDX_OTREV:  rd_byte = {ot_en_q, 3'h0, REVISION};
            default:    rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q   <= req;
            rdata_q <= req ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // Writes land on the edge where the master samples ack
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            speed_q  <= RST_SPEED[3:0];
            filter_q <= RST_FILTER;
            local_q  <= RST_LOCAL;
            remote_q <= RST_REMOTE;
            spinup_q <= RST_SPINUP;
            ot_en_q  <= RST_OT_EN;
        end else if (wr) begin
            if (idx == IDX_SPEED)  speed_q  <= wd[3:0];
            if (idx == IDX_FILTER) filter_q <= wd;
            if (idx == IDX_LOCAL)  local_q  <= wd;
            if (idx == IDX_REMOTE) remote_q <= wd;
            if (idx == IDX_SPINUP) spinup_q <= {wd[F_AUTO_EN], 4'h0, wd[2:0]};
            if (idx == IDX_OTREV)  ot_en_q  <= wd[F_OT_EN];
        end
    end

    assign cfg.base      = speed_q;
    assign cfg.spin_dis  = filter_q[F_SPIN_DIS];
    assign cfg.ramp      = filter_q[F_RAMP_LSB +: 2];
    assign cfg.rate      = filter_q[F_RATE_LSB +: 3];
    assign cfg.filt_en   = filter_q[F_FILT_EN];
    assign cfg.l_tmin    = local_q[F_TMIN_LSB +: 5];
    assign cfg.l_span    = local_q[2:0];
    assign cfg.r_tmin    = remote_q[F_TMIN_LSB +: 5];
    assign cfg.r_span    = remote_q[2:0];
    assign cfg.ot_en     = ot_en_q;
    assign cfg.auto_en   = spinup_q[F_AUTO_EN];
    assign cfg.spin_code = spinup_q[2:0];

    // ****************************************************************
    // Overtemp pin and status flag
    // ****************************************************************
    logic            drive_q;
    wire logic       ext_low = ~therm_i & ~drive_q;
    // Set beats the read-clear so no external event is lost
    wire logic       flag_d  = ext_low | (ext_flag_q & ~st_read);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            drive_q    <= 1'b0;
            ext_flag_q <= 1'b0;
            therm_oe_n <= 1'b1;
        end else begin
            drive_q    <= overtemp_req;
            ext_flag_q <= flag_d;
            therm_oe_n <= ~overtemp_req;
        end
    end

    // ****************************************************************
    // Sampling tick and automatic target
    // ****************************************************************
    logic [35:0]     upd_cnt_q;
    logic [3:0]      auto_q;
    wire logic [35:0] upd_lim = ({4'h0, UPD_CYC} << 4) >> cfg.rate;
    wire logic       upd_tick = (upd_cnt_q >= upd_lim - 36'h1);
    wire logic [3:0] l_lvl = auto_level(local_temp, cfg.l_tmin, cfg.l_span, cfg.base);
    wire logic [3:0] r_lvl = auto_level(remote_temp, cfg.r_tmin, cfg.r_span, cfg.base);
    wire logic [3:0] cmd   = cfg.auto_en ? auto_q : cfg.base;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            upd_cnt_q <= 36'h000000000;
            auto_q    <= RST_SPEED[3:0];
        end else begin
            upd_cnt_q <= upd_tick ? 36'h000000000 : upd_cnt_q + 36'h1;
            if (upd_tick) auto_q <= (l_lvl > r_lvl) ? l_lvl : r_lvl;
        end
    end

    // ****************************************************************
    // Spin-up state machine
    // ****************************************************************
    facc_fan_state_t  st_q;
    facc_fan_state_t  st_d;
    logic [31:0]      spin_cnt_q;
    wire logic        spin_end = (spin_cnt_q >= spin_limit(cfg.spin_code) - 32'h1);

    always_comb begin
        case (st_q)
            FS_IDLE: st_d = (cmd == 4'h0) ? FS_IDLE :
                            (cfg.spin_dis ? FS_RUN : FS_SPIN);
            FS_SPIN: st_d = (cmd == 4'h0) ? FS_IDLE :
                            (spin_end ? FS_RUN : FS_SPIN);
            FS_RUN:  st_d = (cmd == 4'h0) ? FS_IDLE : FS_RUN;
            default: st_d = FS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q       <= FS_IDLE;
            spin_cnt_q <= 32'h00000000;
        end else begin
            st_q       <= st_d;
            spin_cnt_q <= (st_q == FS_SPIN) ? spin_cnt_q + 32'h1 : 32'h00000000;
        end
    end

    // ****************************************************************
    // Ramp, full-speed override and PWM
    // ****************************************************************
    logic [31:0]     presc_q;
    logic [3:0]      slot_q;
    logic [3:0]      lvl_q;
    wire logic       slot_end = (presc_q >= SLOT_CYC - 32'h1);
    wire logic       per_end  = slot_end & (slot_q == DUTY_MAX);
    wire logic [4:0] step     = 5'(5'h01 << cfg.ramp);
    wire logic [4:0] up_v     = 5'(lvl_q) + step;
    wire logic [4:0] dn_v     = 5'(lvl_q) - step;
    logic [3:0]      ramp_v;

    always_comb begin
        if (cmd > lvl_q) begin
            ramp_v = (up_v >= 5'(cmd)) ? cmd : up_v[3:0];
        end else begin
            ramp_v = (dn_v[4] || dn_v[3:0] <= cmd) ? cmd : dn_v[3:0];
        end
    end

    // Own pin assertion forces full only when enabled; external ignored while drive_q is set
    wire logic full = (drive_q & cfg.ot_en) | ext_low
                    | (st_q == FS_SPIN);
    wire logic [3:0] duty = full ? DUTY_MAX : ((st_q == FS_IDLE) ? 4'h0 : lvl_q);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            presc_q <= 32'h00000000;
            slot_q  <= 4'h0;
            lvl_q   <= 4'h0;
            pwm_out <= 1'b0;
        end else begin
            presc_q <= slot_end ? 32'h00000000 : presc_q + 32'h1;
            if (slot_end) slot_q <= slot_q + 4'h1;
            // Level only moves at period ends to avoid runt pulses
            if (per_end) lvl_q <= cfg.filt_en ? ramp_v : cmd;
            pwm_out <= (duty == DUTY_MAX) | (slot_q < duty);
        end
    end

    assign wb_ack_o   = ack_q;
    assign wb_dat_o   = rdata_q;
    assign therm_o    = 1'b0;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_req;
        wb_cyc_i & wb_stb_i & ~ack_q;
    endsequence
    sequence s_ack_pulse;
        ack_q ##1 !ack_q;
    endsequence

    a_bus_ack_pulse: assert property (s_req |=> s_ack_pulse)
        else $error("ack not a one-cycle pulse");
    a_rev_read_only: assert property (s_req ##0 (idx == IDX_OTREV) |=>
        wb_dat_o[6:0] == {3'h0, REVISION}) else $error("revision field wrong");
    a_ext_full_speed: assert property (ext_low |=> pwm_out)
        else $error("external overtemp did not force full");
    a_ext_flag_set: assert property (ext_low |=> ext_flag_q)
        else $error("status flag not set");
    a_flag_read_clear: assert property (st_read & ~ext_low |=> !ext_flag_q)
        else $error("status flag not cleared by read");
    a_own_ot_full: assert property (drive_q & cfg.ot_en |-> duty == DUTY_MAX)
        else $error("enabled overtemp did not force full");
    a_silent_mode: assert property (drive_q & ~cfg.ot_en & ~ext_low & (st_q == FS_RUN)
        |-> duty == lvl_q) else $error("silent mode forced full");
    a_spin_full: assert property ((st_q == FS_SPIN) |-> duty == DUTY_MAX)
        else $error("spin-up not at full");
    a_spin_skip: assert property ((st_q == FS_IDLE) & (cmd != 4'h0) & cfg.spin_dis
        |=> st_q == FS_RUN) else $error("spin-up not skipped");
    a_span_clamp: assert property ((cfg.l_span > SPAN_MAX)
        & (local_temp >= 8'({1'b0, cfg.l_tmin, 2'b00}) + 8'd80) |-> l_lvl == DUTY_MAX)
        else $error("span clamp wrong");
    a_unfiltered_jump: assert property (per_end & ~cfg.filt_en |=>
        lvl_q == $past(cmd)) else $error("unfiltered level not direct");
    a_ramp_bound: assert property (per_end & cfg.filt_en & (cmd > lvl_q) |=>
        lvl_q - $past(lvl_q) <= 4'(step)) else $error("ramp step exceeded");
endmodule

`default_nettype wire

// File: dv/facc_fan_model.sv
// Behavioural fan: measures PWM drive high time and longest high run.
// Assumes each PWM period starts on a rising edge of the drive.
`timescale 1ns/1ps
`default_nettype none
module facc_fan_model (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        pwm_out,
    input  wire logic        clr,
    output logic      [15:0] per_hi,
    output logic      [15:0] run_max
);
    logic        pwm_q;
    logic [15:0] hi_cnt;
    logic [15:0] run_cnt;
    // Full drive has no edges, so run_max covers that case
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_q   <= 1'b0;
            hi_cnt  <= 16'h0000;
            run_cnt <= 16'h0000;
            per_hi  <= 16'h0000;
            run_max <= 16'h0000;
        end else begin
            pwm_q   <= pwm_out;
            run_cnt <= pwm_out ? run_cnt + 16'h0001 : 16'h0000;
            if (pwm_out && !pwm_q) begin
                per_hi <= hi_cnt;
                hi_cnt <= 16'h0001;
            end else begin
                hi_cnt <= hi_cnt + {15'h0000, pwm_out};
            end
            if (clr) begin
                run_max <= 16'h0000;
            end else if (pwm_out && run_cnt >= run_max) begin
                run_max <= run_cnt + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench of the fan auto-control block.
// Assumes Wishbone one-cycle ack and a pulled-up overtemp pin.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import facc_pkg::*;
    localparam int         SLOT = 2;
    localparam int         PER  = 16 * SLOT;
    localparam logic [3:0] REV  = 4'h6; // Arbitrary revision value
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [31:0] wdat = 32'h0;
    logic [7:0]  l_temp = 8'h00;
    logic [7:0]  r_temp = 8'h00;
    logic        ot_req = 1'b0;
    logic        ext_low = 1'b0;
    logic        clr = 1'b0;
    wire  [31:0] rdat;
    wire         ack;
    wire         therm_o;
    wire         therm_oe_n;
    wire         pwm;
    wire  [15:0] per_hi;
    wire  [15:0] run_max;
    wire         therm_w;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          cycles = 0;
    // Open-drain wire with pull-up
    assign therm_w = (!therm_oe_n || ext_low) ? 1'b0 : 1'b1;
    always #2.5 clk = ~clk;
    facc_top #(.SPIN_CYC(32'd20), .UPD_CYC(32'd64), .SLOT_CYC(32'd2), .REVISION(REV)) DUT (
        .clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .local_temp(l_temp), .remote_temp(r_temp), .overtemp_req(ot_req), .therm_i(therm_w),
        .therm_o(therm_o), .therm_oe_n(therm_oe_n), .pwm_out(pwm));
    facc_fan_model FAN (.clk(clk), .reset_n(reset_n), .pwm_out(pwm), .clr(clr),
        .per_hi(per_hi), .run_max(run_max));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        @(posedge clk);
        while (ack !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n >= 50) chk("bus ack", 32'h1, 32'h0);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        wb(1'b1, idx, d, rd);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        wb(1'b0, idx, 8'h00, rd);
        chk(what, {24'h000000, exp}, rd);
    endtask
    task automatic full_chk(input string what);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        // Auto target moves on an update tick, then at a period end
        repeat (6 * PER) @(posedge clk);
        chk(what, 32'h1, 32'(run_max >= 16'(2 * PER)));
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_spinup();
        repeat (240) @(posedge clk);
        chk("spin-up run", 32'h1, 32'(run_max >= 16'd160));
        repeat (300) @(posedge clk);
        chk("base duty", 32'(5 * SLOT), {16'h0, per_hi});
        $display("test spinup done");
    endtask
    task automatic t_regs();
        logic [7:0] idx [6] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h3F, 8'h10};
        logic [7:0] exp [6] = '{8'h05, 8'h50, 8'h41, 8'h61, {4'h8, REV}, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd_chk("reset value", idx[i], exp[i]);
        end
        wr(8'h3F, 8'h7F);
        rd_chk("ot rev", 8'h3F, {4'h0, REV});
        wr(8'h24, 8'hFF);
        rd_chk("local tmin", 8'h24, 8'hFF);
        wr(8'h22, 8'hFF);
        rd_chk("base", 8'h22, 8'h0F);
        wr(8'h24, 8'h41);
        wr(8'h3F, 8'h80);
        wr(8'h23, 8'h90);
        wr(8'h22, 8'h00);
        clr <= 1'b1;
        wr(8'h22, 8'h03);
        clr <= 1'b0;
        repeat (3 * PER) @(posedge clk);
        chk("no spin-up", 32'h1, 32'(run_max < 16'd64));
        $display("test regs done");
    endtask
    task automatic t_ramp();
        logic [7:0]  tgt;
        logic [15:0] prev;
        int          maxd;
        int          d;
        int          step;
        for (int i = 0; i < 5; i++) begin
            tgt  = (i % 2 == 0) ? 8'h0C : 8'h03;
            step = (i < 4) ? (1 << i) : 9;
            wr(8'h23, {1'b1, 2'(i % 4), 3'b100, 1'b0, (i < 4)});
            wr(8'h22, tgt);
            prev = per_hi;
            maxd = 0;
            repeat (13 * PER) begin
                @(posedge clk);
                d = int'(per_hi) - int'(prev);
                if (d < 0) d = -d;
                if (d > maxd) maxd = d;
                prev = per_hi;
            end
            chk("ramp step", 32'(step * SLOT), 32'(maxd));
            chk("ramp end", 32'(tgt) * SLOT, {16'h0, per_hi});
        end
        wr(8'h22, 8'h03);
        repeat (3 * PER) @(posedge clk);
        $display("test ramp done");
    endtask
    task automatic t_overtemp();
        ot_req <= 1'b1;
        repeat (2) @(posedge clk);
        chk("pin driven", 32'h0, {31'h0, therm_oe_n});
        chk("pin data", 32'h0, {31'h0, therm_o});
        full_chk("ot full");
        ot_req <= 1'b0;
        wr(8'h3F, 8'h00);
        ot_req <= 1'b1;
        repeat (4 * PER) @(posedge clk);
        chk("silent duty", 32'(3 * SLOT), {16'h0, per_hi});
        ot_req <= 1'b0;
        ext_low <= 1'b1;
        repeat (3) @(posedge clk);
        chk("ext full", 32'h1, {31'h0, pwm});
        chk("pin released", 32'h1, {31'h0, therm_oe_n});
        rd_chk("ext flag", 8'h03, 8'h80);
        ext_low <= 1'b0;
        // Read while pin still low keeps the flag: set wins
        rd_chk("flag kept", 8'h03, 8'h80);
        rd_chk("flag clear", 8'h03, 8'h00);
        wr(8'h3F, 8'h80);
        $display("test overtemp done");
    endtask
    task automatic t_auto();
        wr(8'h20, 8'h85);
        l_temp <= 8'd20;
        repeat (5 * PER) @(posedge clk);
        chk("auto floor", 32'(3 * SLOT), {16'h0, per_hi});
        l_temp <= 8'd50;
        full_chk("local full");
        // Span code 111 acts as 80 degrees
        wr(8'h24, 8'h47);
        repeat (6 * PER) @(posedge clk);
        chk("wide span", 32'((3 + ((18 * 13) >> 6)) * SLOT), {16'h0, per_hi});
        l_temp <= 8'd120;
        full_chk("wide span full");
        l_temp <= 8'd0;
        r_temp <= 8'd60;
        full_chk("remote full");
        $display("test auto done");
    endtask
    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        t_spinup();
        t_regs();
        t_ramp();
        t_overtemp();
        t_auto();
        stop_test();
    end
endmodule
`default_nettype wire
